/* rtca_defines.vh */
// constants and register layout of the calendar alarm block
`ifndef RTCA_DEFINES_VH
`define RTCA_DEFINES_VH

// register offsets
`define RTCA_ADDR_CONFIG    4'h0
`define RTCA_ADDR_REPEAT    4'h1
`define RTCA_ADDR_SEC       4'h2
`define RTCA_ADDR_MIN       4'h3
`define RTCA_ADDR_HOUR      4'h4
`define RTCA_ADDR_WDAY      4'h5
`define RTCA_ADDR_DAY       4'h6
`define RTCA_ADDR_MONTH     4'h7
`define RTCA_ADDR_PAD       4'h8
`define RTCA_ADDR_INT_STAT  4'h9
`define RTCA_ADDR_INT_MASK  4'hA
`define RTCA_ADDR_STATE     4'hB

// alarm_config fields
`define RTCA_CFG_EN_BIT     7
`define RTCA_CFG_INDEFINITE_REPEAT_BIT  6
`define RTCA_CFG_MASK_HI    5
`define RTCA_CFG_MASK_LO    2

// pad_config field of the pin output select
`define RTCA_PAD_SEL_HI     2
`define RTCA_PAD_SEL_LO     1

// interval mask codes
`define RTCA_MASK_HALF_SEC  4'h0
`define RTCA_MASK_SEC       4'h1
`define RTCA_MASK_TEN_SEC   4'h2
`define RTCA_MASK_MIN       4'h3
`define RTCA_MASK_TEN_MIN   4'h4
`define RTCA_MASK_HOUR      4'h5
`define RTCA_MASK_DAY       4'h6
`define RTCA_MASK_WEEK      4'h7
`define RTCA_MASK_MONTH     4'h8
`define RTCA_MASK_YEAR      4'h9

// pin output select codes
`define RTCA_SEL_PULSE      2'h0
`define RTCA_SEL_SECONDS    2'h1

// repeat count limits and leap day in bcd
`define RTCA_RPT_MAX        8'hFF
`define RTCA_RPT_ZERO       8'h00
`define RTCA_FEB_BCD        8'h02
`define RTCA_DAY29_BCD      8'h29

// reset values
`define RTCA_CONFIG_RST     8'h00
`define RTCA_REPEAT_RST     8'h00
`define RTCA_PAD_RST        2'h0

`endif

/* rtca_match.v */
// interval mask decoder and field comparator for the alarm
`timescale 1ns/10ps
`include "rtca_defines.vh"

module rtca_match (
   mask,
   half_tick,
   sec_tick,
   now_sec,
   now_min,
   now_hour,
   now_wday,
   now_day,
   now_month,
   al_sec,
   al_min,
   al_hour,
   al_wday,
   al_day,
   al_month,
   hit
);
   input  wire [3:0] mask;
   input  wire       half_tick;
   input  wire       sec_tick;
   input  wire [7:0] now_sec;
   input  wire [7:0] now_min;
   input  wire [7:0] now_hour;
   input  wire [2:0] now_wday;
   input  wire [7:0] now_day;
   input  wire [7:0] now_month;
   input  wire [7:0] al_sec;
   input  wire [7:0] al_min;
   input  wire [7:0] al_hour;
   input  wire [2:0] al_wday;
   input  wire [7:0] al_day;
   input  wire [7:0] al_month;
   output reg        hit;

   wire sec_lo_eq = (now_sec[3:0] == al_sec[3:0]);
   wire sec_eq    = (now_sec == al_sec);
   wire min_lo_eq = (now_min[3:0] == al_min[3:0]);
   wire min_eq    = (now_min == al_min);
   wire hour_eq   = (now_hour == al_hour);
   wire wday_eq   = (now_wday == al_wday);
   wire day_eq    = (now_day == al_day);
   wire month_eq  = (now_month == al_month);
   // a february 29 alarm would only fire in leap years, so with the yearly mask it never does
   wire leap_day  = (al_month == `RTCA_FEB_BCD) &&
                    (al_day == `RTCA_DAY29_BCD);

   always @* begin
      case (mask)
         `RTCA_MASK_HALF_SEC: hit = half_tick;
         `RTCA_MASK_SEC:      hit = sec_tick;
         `RTCA_MASK_TEN_SEC:  hit = sec_tick && sec_lo_eq;
         `RTCA_MASK_MIN:      hit = sec_tick && sec_eq;
         `RTCA_MASK_TEN_MIN:  hit = sec_tick && sec_eq && min_lo_eq;
         `RTCA_MASK_HOUR:     hit = sec_tick && sec_eq && min_eq;
         `RTCA_MASK_DAY:
            hit = sec_tick && sec_eq && min_eq && hour_eq;
         `RTCA_MASK_WEEK:
            hit = sec_tick && sec_eq && min_eq && hour_eq && wday_eq;
         `RTCA_MASK_MONTH:
            hit = sec_tick && sec_eq && min_eq && hour_eq && day_eq;
         `RTCA_MASK_YEAR:
            hit = sec_tick && sec_eq && min_eq && hour_eq && day_eq &&
                  month_eq && !leap_day;
         default:             hit = 1'b0;
      endcase
   end

endmodule // rtca_match

/* rtca_pin.v */
// alarm pulse toggle and calendar pin output select
`timescale 1ns/10ps
`include "rtca_defines.vh"

module rtca_pin (
   core_clk,
   sys_rst,
   alarm_event,
   sec_clk,
   pin_sel,
   pulse_level,
   pin_out
);
   input  wire       core_clk;
   input  wire       sys_rst;
   input  wire       alarm_event;
   input  wire       sec_clk;
   input  wire [1:0] pin_sel;
   output wire       pulse_level;
   output reg        pin_out;

   reg pulse_r;
   reg pulse_nxt;
   reg pin_nxt;

   always @* begin
      pulse_nxt = pulse_r ^ alarm_event;
      case (pin_sel)
         `RTCA_SEL_PULSE:   pin_nxt = pulse_nxt;
         `RTCA_SEL_SECONDS: pin_nxt = sec_clk;
         default:           pin_nxt = 1'b0;
      endcase
   end

   always @(posedge core_clk) begin
      if (sys_rst) begin
         pulse_r <= 1'b0;
         pin_out <= 1'b0;
      end else begin
         pulse_r <= pulse_nxt;
         pin_out <= pin_nxt;
      end
   end

   assign pulse_level = pulse_r;

endmodule // rtca_pin

/* rtca_alarm.v */
// calendar alarm with repeat counter, interrupt and pin output
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`include "rtca_defines.vh"

module rtca_alarm (
   core_clk,
   sys_rst,
   reg_addr,
   reg_wdata,
   reg_wr,
   reg_rd,
   reg_rdata,
   half_tick,
   sec_tick,
   sec_clk,
   now_sec,
   now_min,
   now_hour,
   now_wday,
   now_day,
   now_month,
   alarm_event,
   alarm_irq,
   calendar_pin
);
   parameter AW = 4;
   parameter DW = 8;

   input  wire          core_clk;
   input  wire          sys_rst;
   input  wire [AW-1:0] reg_addr;
   input  wire [DW-1:0] reg_wdata;
   input  wire          reg_wr;
   input  wire          reg_rd;
   output reg  [DW-1:0] reg_rdata;
   input  wire          half_tick;
   input  wire          sec_tick;
   input  wire          sec_clk;
   input  wire [7:0]    now_sec;
   input  wire [7:0]    now_min;
   input  wire [7:0]    now_hour;
   input  wire [2:0]    now_wday;
   input  wire [7:0]    now_day;
   input  wire [7:0]    now_month;
   output reg           alarm_event;
   output reg           alarm_irq;
   output wire          calendar_pin;

   ////////////////////////////////////////////////////////////////////////
   // registers

   reg        alarm_enable_r;
   reg        indefinite_repeat_r;
   reg [3:0]  alarm_interval_mask_r;
   reg [7:0]  alarm_repeat_count_r;
   reg [7:0]  al_sec_r;
   reg [7:0]  al_min_r;
   reg [7:0]  al_hour_r;
   reg [2:0]  al_wday_r;
   reg [7:0]  al_day_r;
   reg [7:0]  al_month_r;
   reg [1:0]  calendar_pin_output_select_r;
   reg        int_stat_r;
   reg        int_mask_r;

   reg        alarm_enable_nxt;
   reg [7:0]  alarm_repeat_count_nxt;
   reg        int_stat_nxt;
   reg [DW-1:0] rdata_nxt;

   wire       hit;
   wire       event_now;
   wire       pulse_level;

   wire wr_cfg   = reg_wr && (reg_addr == `RTCA_ADDR_CONFIG);
   wire wr_rpt   = reg_wr && (reg_addr == `RTCA_ADDR_REPEAT);
   wire wr_istat = reg_wr && (reg_addr == `RTCA_ADDR_INT_STAT);

   ////////////////////////////////////////////////////////////////////////
   // match and event

   rtca_match u_match (
      .mask      (alarm_interval_mask_r),
      .half_tick (half_tick),
      .sec_tick  (sec_tick),
      .now_sec   (now_sec),
      .now_min   (now_min),
      .now_hour  (now_hour),
      .now_wday  (now_wday),
      .now_day   (now_day),
      .now_month (now_month),
      .al_sec    (al_sec_r),
      .al_min    (al_min_r),
      .al_hour   (al_hour_r),
      .al_wday   (al_wday_r),
      .al_day    (al_day_r),
      .al_month  (al_month_r),
      .hit       (hit)
   );

   assign event_now = alarm_enable_r && hit;

   ////////////////////////////////////////////////////////////////////////
   // repeat counter and auto disable

   // a software write in the same cycle as an event takes precedence,
   // so a fresh configuration is never overwritten by the old count
   always @* begin
      alarm_enable_nxt       = alarm_enable_r;
      alarm_repeat_count_nxt = alarm_repeat_count_r;
      if (event_now) begin
         if (alarm_repeat_count_r != `RTCA_RPT_ZERO)
            alarm_repeat_count_nxt = alarm_repeat_count_r - 8'h01;
         else if (indefinite_repeat_r)
            alarm_repeat_count_nxt = `RTCA_RPT_MAX;
         else
            alarm_enable_nxt = 1'b0;
      end
      if (wr_cfg)
         alarm_enable_nxt = reg_wdata[`RTCA_CFG_EN_BIT];
      if (wr_rpt)
         alarm_repeat_count_nxt = reg_wdata[7:0];
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt status, set wins over write-one clear

   always @* begin
      int_stat_nxt = int_stat_r;
      if (wr_istat && reg_wdata[0])
         int_stat_nxt = 1'b0;
      if (event_now)
         int_stat_nxt = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux

   always @* begin
      rdata_nxt = {DW{1'b0}};
      if (reg_rd) begin
         case (reg_addr)
            `RTCA_ADDR_CONFIG:
               rdata_nxt = {alarm_enable_r, indefinite_repeat_r,
                            alarm_interval_mask_r, 2'h0};
            `RTCA_ADDR_REPEAT:   rdata_nxt = alarm_repeat_count_r;
            `RTCA_ADDR_SEC:      rdata_nxt = al_sec_r;
            `RTCA_ADDR_MIN:      rdata_nxt = al_min_r;
            `RTCA_ADDR_HOUR:     rdata_nxt = al_hour_r;
            `RTCA_ADDR_WDAY:     rdata_nxt = {5'h00, al_wday_r};
            `RTCA_ADDR_DAY:      rdata_nxt = al_day_r;
            `RTCA_ADDR_MONTH:    rdata_nxt = al_month_r;
            `RTCA_ADDR_PAD:
               rdata_nxt = {5'h00, calendar_pin_output_select_r, 1'b0};
            `RTCA_ADDR_INT_STAT: rdata_nxt = {7'h00, int_stat_r};
            `RTCA_ADDR_INT_MASK: rdata_nxt = {7'h00, int_mask_r};
            `RTCA_ADDR_STATE:    rdata_nxt = {7'h00, pulse_level};
            default:             rdata_nxt = {DW{1'b0}};
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state registers

   always @(posedge core_clk) begin
      if (sys_rst) begin
         alarm_enable_r               <= 1'b0;
         indefinite_repeat_r          <= 1'b0;
         alarm_interval_mask_r        <= 4'h0;
         alarm_repeat_count_r         <= `RTCA_REPEAT_RST;
         al_sec_r                     <= 8'h00;
         al_min_r                     <= 8'h00;
         al_hour_r                    <= 8'h00;
         al_wday_r                    <= 3'h0;
         al_day_r                     <= 8'h01;
         al_month_r                   <= 8'h01;
         calendar_pin_output_select_r <= `RTCA_PAD_RST;
         int_stat_r                   <= 1'b0;
         int_mask_r                   <= 1'b0;
         reg_rdata                    <= {DW{1'b0}};
         alarm_event                  <= 1'b0;
         alarm_irq                    <= 1'b0;
      end else begin
         alarm_enable_r       <= alarm_enable_nxt;
         alarm_repeat_count_r <= alarm_repeat_count_nxt;
         int_stat_r           <= int_stat_nxt;
         reg_rdata            <= rdata_nxt;
         alarm_event          <= event_now;
         alarm_irq            <= int_stat_nxt && int_mask_r;
         if (wr_cfg) begin
            indefinite_repeat_r   <= reg_wdata[`RTCA_CFG_INDEFINITE_REPEAT_BIT];
            alarm_interval_mask_r <=
               reg_wdata[`RTCA_CFG_MASK_HI:`RTCA_CFG_MASK_LO];
         end
         if (reg_wr) begin
            case (reg_addr)
               `RTCA_ADDR_SEC:      al_sec_r   <= reg_wdata;
               `RTCA_ADDR_MIN:      al_min_r   <= reg_wdata;
               `RTCA_ADDR_HOUR:     al_hour_r  <= reg_wdata;
               `RTCA_ADDR_WDAY:     al_wday_r  <= reg_wdata[2:0];
               `RTCA_ADDR_DAY:      al_day_r   <= reg_wdata;
               `RTCA_ADDR_MONTH:    al_month_r <= reg_wdata;
               `RTCA_ADDR_PAD:
                  calendar_pin_output_select_r <=
                     reg_wdata[`RTCA_PAD_SEL_HI:`RTCA_PAD_SEL_LO];
               `RTCA_ADDR_INT_MASK: int_mask_r <= reg_wdata[0];
               default:             int_mask_r <= int_mask_r;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin output

   rtca_pin u_pin (
      .core_clk    (core_clk),
      .sys_rst     (sys_rst),
      .alarm_event (event_now),
      .sec_clk     (sec_clk),
      .pin_sel     (calendar_pin_output_select_r),
      .pulse_level (pulse_level),
      .pin_out     (calendar_pin)
   );

endmodule // rtca_alarm

/* rtca_alarm_sva.sv */
// assertions for the calendar alarm block
`timescale 1ns/10ps
module rtca_alarm_sva #(parameter AW = 4, parameter DW = 8) (
   input wire logic          core_clk,
   input wire logic          sys_rst,
   input wire logic [AW-1:0] reg_addr,
   input wire logic [DW-1:0] reg_wdata,
   input wire logic          reg_wr,
   input wire logic          half_tick,
   input wire logic          sec_clk,
   input wire logic          alarm_event,
   input wire logic          alarm_irq,
   input wire logic          calendar_pin
);
   // shadow of software writes; hardware only ever clears enable
   logic [DW-1:0] cfg_r;
   logic          msk_r;
   logic [1:0]    sel_r;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cfg_r <= 8'h00;
         msk_r <= 1'b0;
         sel_r <= 2'h0;
      end else if (reg_wr) begin
         if (reg_addr == 4'h0) cfg_r <= reg_wdata;
         if (reg_addr == 4'hA) msk_r <= reg_wdata[0];
         if (reg_addr == 4'h8) sel_r <= reg_wdata[2:1];
      end
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   sequence indefinite_repeat_half_s;
      half_tick && cfg_r == 8'hC0;
   endsequence
   tick_cause_a: assert property (!half_tick |=> !alarm_event)
      else $error("alarm event without a tick");
   enable_gate_a: assert property (!cfg_r[7] |=> !alarm_event)
      else $error("alarm event while disabled");
   halfsec_every_a: assert property (indefinite_repeat_half_s |=> alarm_event)
      else $error("half second alarm missed");
   event_pulse_a: assert property (alarm_event |=> !alarm_event)
      else $error("alarm event longer than one cycle");
   irq_on_event_a: assert property (
      alarm_event && msk_r && $past(msk_r) |-> alarm_irq)
      else $error("no interrupt on alarm event");
   irq_masked_a: assert property (
      !msk_r && !$past(msk_r) |-> !alarm_irq)
      else $error("interrupt while masked");
   // pin follows the select of the cycle before, hence depths 1 and 2
   pulse_toggle_a: assert property (
      alarm_event && $past(sel_r) == 2'h0 && $past(sel_r, 2) == 2'h0
      |-> calendar_pin != $past(calendar_pin))
      else $error("alarm pulse did not toggle");
   sec_route_a: assert property (
      sel_r == 2'h1 && $past(sel_r) == 2'h1
      |-> calendar_pin == $past(sec_clk))
      else $error("seconds clock not on pin");
endmodule // rtca_alarm_sva

bind rtca_alarm rtca_alarm_sva #(.AW(AW), .DW(DW)) chk_u (
   .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .half_tick(half_tick),
   .sec_clk(sec_clk), .alarm_event(alarm_event), .alarm_irq(alarm_irq),
   .calendar_pin(calendar_pin));

/* tb.sv */
// self-checking bench of the calendar alarm block
`timescale 1ns/10ps
module tb;
   logic       core_clk, sys_rst, reg_wr, reg_rd, ht, st, sec_clk;
   logic       alarm_event, alarm_irq, calendar_pin;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, n_s, n_m, n_h, n_d, n_mo;
   logic [2:0] n_w;
   int         n_errors, check_count, cyc;

   rtca_alarm dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .half_tick(ht),
      .sec_tick(st), .sec_clk(sec_clk), .now_sec(n_s), .now_min(n_m),
      .now_hour(n_h), .now_wday(n_w), .now_day(n_d), .now_month(n_mo),
      .alarm_event(alarm_event), .alarm_irq(alarm_irq),
      .calendar_pin(calendar_pin));

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   // half tick always, second tick on request; event lands one edge later
   task automatic tick(input logic s, input logic e);
      @(posedge core_clk);
      ht <= 1'b1;
      st <= s;
      @(posedge core_clk);
      ht <= 1'b0;
      st <= 1'b0;
      #1 chk({7'h00, alarm_event}, {7'h00, e});
      @(posedge core_clk);
   endtask
   task automatic flip(input int m);
      @(posedge core_clk);
      case (m)
         2: n_s <= n_s ^ 8'h01;
         3: n_s <= n_s ^ 8'h10;
         4: n_m <= n_m ^ 8'h01;
         5: n_m <= n_m ^ 8'h10;
         6: n_h <= n_h ^ 8'h01;
         7: n_w <= n_w ^ 3'h1;
         8: n_d <= n_d ^ 8'h01;
         default: n_mo <= n_mo ^ 8'h01;
      endcase
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rd(4'h0, 8'h00);
      rd(4'h1, 8'h00);
      rd(4'h6, 8'h01);
      @(posedge core_clk);
      #1 chk(reg_rdata, 8'h00);
      rd(4'h7, 8'h01);
      rd(4'hC, 8'h00);
   endtask
   task automatic t_masks;
      wr(4'h2, n_s);
      wr(4'h3, n_m);
      wr(4'h4, n_h);
      wr(4'h5, {5'h00, n_w});
      wr(4'h6, n_d);
      wr(4'h7, n_mo);
      wr(4'h0, 8'hC0);
      tick(1'b0, 1'b1);
      wr(4'h0, 8'hC4);
      tick(1'b0, 1'b0);
      tick(1'b1, 1'b1);
      for (int m = 2; m < 10; m++) begin
         wr(4'h0, {2'b11, m[3:0], 2'b00});
         tick(1'b1, 1'b1);
         flip(m);
         tick(1'b1, 1'b0);
         flip(m);
      end
      wr(4'h6, 8'h29);
      wr(4'h7, 8'h02);
      @(posedge core_clk);
      n_d <= 8'h29;
      n_mo <= 8'h02;
      tick(1'b1, 1'b0);
      wr(4'h0, 8'hE0);
      tick(1'b1, 1'b1);
      wr(4'h0, 8'hE8);
      tick(1'b1, 1'b0);
      wr(4'h0, 8'h44);
      tick(1'b1, 1'b0);
   endtask
   task automatic t_repeat;
      wr(4'h9, 8'h01);
      rd(4'h9, 8'h00);
      wr(4'hA, 8'h01);
      wr(4'h1, 8'h00);
      wr(4'h0, 8'h84);
      tick(1'b1, 1'b1);
      rd(4'h0, 8'h04);
      tick(1'b1, 1'b0);
      rd(4'h9, 8'h01);
      chk({7'h00, alarm_irq}, 8'h01);
      wr(4'h9, 8'h01);
      @(posedge core_clk);
      #1 chk({7'h00, alarm_irq}, 8'h00);
      wr(4'h1, 8'hFF);
      wr(4'h0, 8'h84);
      tick(1'b1, 1'b1);
      rd(4'h1, 8'hFE);
      wr(4'h1, 8'h01);
      tick(1'b1, 1'b1);
      rd(4'h1, 8'h00);
      tick(1'b1, 1'b1);
      tick(1'b1, 1'b0);
   endtask
   task automatic t_indefinite_repeat_pin;
      logic p;
      wr(4'h8, 8'h00);
      wr(4'h1, 8'h00);
      wr(4'h0, 8'hC4);
      #1 p = calendar_pin;
      tick(1'b1, 1'b1);
      chk({7'h00, calendar_pin}, {7'h00, ~p});
      rd(4'h1, 8'hFF);
      rd(4'h0, 8'hC4);
      rd(4'hB, {7'h00, ~p});
      tick(1'b1, 1'b1);
      chk({7'h00, calendar_pin}, {7'h00, p});
      rd(4'h1, 8'hFE);
      wr(4'h8, 8'h02);
      sec_clk <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1 chk({7'h00, calendar_pin}, 8'h01);
      sec_clk <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1 chk({7'h00, calendar_pin}, 8'h00);
      wr(4'h8, 8'h04);
      sec_clk <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1 chk({7'h00, calendar_pin}, 8'h00);
   endtask
   // reset in mid-run, with irq, enable and pin select all active
   task automatic t_rerst;
      @(posedge core_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      #1 chk({5'h00, alarm_irq, alarm_event, calendar_pin}, 8'h00);
      rd(4'h0, 8'h00);
      rd(4'hA, 8'h00);
      rd(4'h8, 8'h00);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic final_report;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         final_report;
      end
   end
   initial begin
      {reg_wr, reg_rd, ht, st, sec_clk} = 5'h00;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      {n_s, n_m, n_h, n_w} = {8'h56, 8'h34, 8'h12, 3'h3};
      {n_d, n_mo} = {8'h15, 8'h07};
      sys_rst = 1'b1;
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_reset;
      t_masks;
      t_repeat;
      t_indefinite_repeat_pin;
      t_rerst;
      final_report;
   end
endmodule // tb
